// *** logic/eep_port.sv ***
// Function
// - Data in and out share one pin
// - Read drives dummy zero at last address bit
// - After programming, drive ready/busy while selected
// - Start bit releases output to high impedance
// - Ready plus input high plus clock is start
// - Write frame: start, opcode, address, data
// - Write cancellable only before 27th clock
// - Ignore commands during programming cycle
module eep_port #(
  parameter int ADDR_W      = 8,
  parameter int DATA_W      = 16,
  parameter int PROG_CYCLES = eep_pkg::PROG_TIME_NS / eep_pkg::CLK_PERIOD_NS
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_ce,
  input  wire logic i_chip_select_pin,
  input  wire logic i_serial_clock_pin,
  input  wire logic i_shared_data_pin,
  output logic      o_shared_data_pin,
  output logic      o_shared_data_oe
);

  localparam int         BUSY_W     = $clog2(PROG_CYCLES + 1);
  localparam logic [4:0] ADDR_LAST  = 5'(eep_pkg::START_BITS + eep_pkg::OP_BITS + ADDR_W);
  localparam logic [4:0] WRITE_LAST = 5'(eep_pkg::START_BITS + eep_pkg::OP_BITS + ADDR_W
                                         + DATA_W);
  localparam logic [4:0] RD_LAST    = 5'(DATA_W - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_s3_reg;
  logic sdat_s1_reg;
  logic sdat_s2_reg;
  logic sclk_rise;
  logic cs_on;
  logic sdat_in;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cs_s1_reg   <= 1'b0;
      cs_s2_reg   <= 1'b0;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      sdat_s1_reg <= 1'b0;
      sdat_s2_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      cs_s1_reg   <= i_chip_select_pin;
      cs_s2_reg   <= cs_s1_reg;
      sclk_s1_reg <= i_serial_clock_pin;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      sdat_s1_reg <= i_shared_data_pin;
      sdat_s2_reg <= sdat_s1_reg;
    end
  end

  assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  assign cs_on     = cs_s2_reg;
  assign sdat_in   = sdat_s2_reg;

  // ****************************************
  // Command engine
  // ****************************************
  eep_pkg::eep_state_t state_reg;
  eep_pkg::eep_state_t state_next;
  logic [4:0]          cnt_reg;
  logic [4:0]          cnt_next;
  logic [4:0]          cnt_inc;
  logic [DATA_W-1:0]   sh_reg;
  logic [DATA_W-1:0]   sh_next;
  logic [DATA_W-1:0]   sh_full;
  logic [ADDR_W-1:0]   addr_reg;
  logic [ADDR_W-1:0]   addr_next;
  logic [BUSY_W-1:0]   busy_reg;
  logic [BUSY_W-1:0]   busy_next;
  logic                wen_reg;
  logic                wen_next;
  logic                out_reg;
  logic                out_next;
  logic                oe_reg;
  logic                oe_next;
  logic                mem_we;
  logic [DATA_W-1:0]   mem_wdata;
  logic [DATA_W-1:0]   mem_rdata;
  logic [1:0]          op_code;

  assign cnt_inc = cnt_reg + 5'h01;
  assign sh_full = {sh_reg[DATA_W-2:0], sdat_in};
  assign op_code = sh_full[ADDR_W+1:ADDR_W];

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    addr_next  = addr_reg;
    busy_next  = busy_reg;
    wen_next   = wen_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    mem_we     = 1'b0;
    mem_wdata  = sh_full;
    case (state_reg)
      eep_pkg::EEP_PROG:
      begin
        oe_next  = cs_on;
        out_next = eep_pkg::BUSY_LVL;
        if (busy_reg == '0)
        begin
          state_next = eep_pkg::EEP_STAT;
          out_next   = eep_pkg::READY_LVL;
        end
        else
        begin
          busy_next = busy_reg - {{(BUSY_W-1){1'b0}}, 1'b1};
        end
      end
      eep_pkg::EEP_STAT:
      begin
        oe_next  = cs_on;
        out_next = eep_pkg::READY_LVL;
        // Start bit seen even on own ready level
        if (cs_on && sclk_rise && sdat_in)
        begin
          oe_next    = 1'b0;
          state_next = eep_pkg::EEP_CMD;
          cnt_next   = eep_pkg::CNT_START;
        end
      end
      default:
      begin
        if (!cs_on)
        begin
          oe_next    = 1'b0;
          state_next = eep_pkg::EEP_IDLE;
        end
        else
        begin
          case (state_reg)
            eep_pkg::EEP_IDLE:
            begin
              if (sclk_rise && sdat_in)
              begin
                state_next = eep_pkg::EEP_CMD;
                cnt_next   = eep_pkg::CNT_START;
              end
            end
            eep_pkg::EEP_CMD:
            begin
              if (sclk_rise)
              begin
                sh_next  = sh_full;
                cnt_next = cnt_inc;
                if (cnt_inc == ADDR_LAST)
                begin
                  addr_next = sh_full[ADDR_W-1:0];
                  cnt_next  = eep_pkg::CNT_ZERO;
                  case (op_code)
                    eep_pkg::OP_READ:
                    begin
                      // Dummy zero on last address bit
                      out_next   = eep_pkg::DUMMY_BIT;
                      oe_next    = 1'b1;
                      state_next = eep_pkg::EEP_FETCH;
                    end
                    eep_pkg::OP_WRITE:
                    begin
                      state_next = eep_pkg::EEP_WDATA;
                    end
                    eep_pkg::OP_ERASE:
                    begin
                      mem_we     = wen_reg;
                      mem_wdata  = {DATA_W{1'b1}};
                      busy_next  = BUSY_W'(PROG_CYCLES - 1);
                      state_next = wen_reg ? eep_pkg::EEP_PROG : eep_pkg::EEP_IDLE;
                    end
                    default:
                    begin
                      if (sh_full[ADDR_W-1 -: 2] == eep_pkg::MISC_EWEN)
                      begin
                        wen_next = 1'b1;
                      end
                      else if (sh_full[ADDR_W-1 -: 2] == eep_pkg::MISC_EWDS)
                      begin
                        wen_next = 1'b0;
                      end
                      state_next = eep_pkg::EEP_IDLE;
                    end
                  endcase
                end
              end
            end
            eep_pkg::EEP_FETCH:
            begin
              state_next = eep_pkg::EEP_LOAD;
            end
            eep_pkg::EEP_LOAD:
            begin
              sh_next    = mem_rdata;
              state_next = eep_pkg::EEP_RDATA;
            end
            eep_pkg::EEP_RDATA:
            begin
              if (sclk_rise)
              begin
                out_next = sh_reg[DATA_W-1];
                sh_next  = {sh_reg[DATA_W-2:0], 1'b0};
                cnt_next = cnt_inc;
                if (cnt_reg == RD_LAST)
                begin
                  addr_next  = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
                  cnt_next   = eep_pkg::CNT_ZERO;
                  state_next = eep_pkg::EEP_FETCH;
                end
              end
            end
            eep_pkg::EEP_WDATA:
            begin
              if (sclk_rise)
              begin
                sh_next  = sh_full;
                cnt_next = cnt_inc;
                // Commit on the last data edge
                if (cnt_inc + ADDR_LAST == WRITE_LAST)
                begin
                  mem_we     = wen_reg;
                  busy_next  = BUSY_W'(PROG_CYCLES - 1);
                  state_next = wen_reg ? eep_pkg::EEP_PROG : eep_pkg::EEP_IDLE;
                end
              end
            end
            default:
            begin
              state_next = eep_pkg::EEP_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= eep_pkg::EEP_IDLE;
      cnt_reg   <= eep_pkg::CNT_ZERO;
      sh_reg    <= '0;
      addr_reg  <= '0;
      busy_reg  <= '0;
      wen_reg   <= 1'b0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
    end
    else if (i_ce)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      addr_reg  <= addr_next;
      busy_reg  <= busy_next;
      wen_reg   <= wen_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
    end
  end

  assign o_shared_data_pin = out_reg;
  assign o_shared_data_oe  = oe_reg;

  eep_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) eep_mem_i (
    .i_clk   (i_clk),
    .i_ce    (i_ce & ~i_sys_rst),
    .i_we    (mem_we & i_ce),
    .i_waddr (addr_next),
    .i_wdata (mem_wdata),
    .i_raddr (addr_reg),
    .o_rdata (mem_rdata)
  );

  // ****************************************
  // Checks
  // ****************************************
  dummy_zero_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state_reg == eep_pkg::EEP_CMD && cs_on && sclk_rise && cnt_inc == ADDR_LAST
     && op_code == eep_pkg::OP_READ) |=> (o_shared_data_oe && !o_shared_data_pin)
  ) else $error("dummy zero not driven on last address bit");

  busy_drive_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state_reg == eep_pkg::EEP_PROG && cs_on && busy_reg != '0)
    |=> (o_shared_data_oe && o_shared_data_pin == eep_pkg::BUSY_LVL)
  ) else $error("busy level not driven while selected");

  ready_drive_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state_reg == eep_pkg::EEP_STAT && cs_on && !(sclk_rise && sdat_in))
    |=> (o_shared_data_oe && o_shared_data_pin == eep_pkg::READY_LVL)
  ) else $error("ready level not driven while selected");

  start_release_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state_reg == eep_pkg::EEP_STAT && cs_on && sclk_rise && sdat_in)
    |=> (!o_shared_data_oe && state_reg == eep_pkg::EEP_CMD && cnt_reg == eep_pkg::CNT_START)
  ) else $error("start bit did not release the pin");

  prog_hold_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (state_reg == eep_pkg::EEP_PROG && busy_reg != '0) |=> (state_reg == eep_pkg::EEP_PROG)
  ) else $error("programming cycle left early");

  write_cancel_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state_reg == eep_pkg::EEP_WDATA && !cs_on)
    |-> (!mem_we ##1 state_reg == eep_pkg::EEP_IDLE)
  ) else $error("deselect did not cancel the write");

  write_commit_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state_reg == eep_pkg::EEP_WDATA && cs_on && sclk_rise && wen_reg
     && cnt_inc + ADDR_LAST == WRITE_LAST)
    |-> (mem_we ##1 state_reg == eep_pkg::EEP_PROG)
  ) else $error("write not committed on final data edge");

  read_shift_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state_reg == eep_pkg::EEP_RDATA && cs_on && sclk_rise)
    |=> (o_shared_data_oe && o_shared_data_pin == $past(sh_reg[DATA_W-1]))
  ) else $error("read data bit not shifted out");

endmodule

// *** include/eep_pkg.sv ***
package eep_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int         START_BITS = 1;
  localparam int         OP_BITS    = 2;
  localparam int         CNT_W      = 5;
  localparam logic [4:0] CNT_START  = 5'h01;
  localparam logic [4:0] CNT_ZERO   = 5'h00;

  // ****************************************
  // Operation codes and sub-codes
  // ****************************************
  localparam logic [1:0] OP_MISC    = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] MISC_EWEN  = 2'h3;
  localparam logic [1:0] MISC_EWDS  = 2'h0;

  // ****************************************
  // Output levels
  // ****************************************
  localparam logic       DUMMY_BIT  = 1'b0;
  localparam logic       BUSY_LVL   = 1'b0;
  localparam logic       READY_LVL  = 1'b1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         CLK_PERIOD_NS = 40;
  localparam int         PROG_TIME_NS  = 5000000;

  typedef enum logic [2:0] {
    EEP_IDLE,
    EEP_CMD,
    EEP_FETCH,
    EEP_LOAD,
    EEP_RDATA,
    EEP_WDATA,
    EEP_PROG,
    EEP_STAT
  } eep_state_t;

endpackage

// *** logic/eep_mem.sv ***
module eep_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_ce,
  input  wire logic              i_we,
  input  wire logic [ADDR_W-1:0] i_waddr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [ADDR_W-1:0] i_raddr,
  output logic      [DATA_W-1:0] o_rdata
);

  logic [DATA_W-1:0] mem_array [2**ADDR_W];
  logic [DATA_W-1:0] rdata_next;

  always_comb
  begin
    rdata_next = mem_array[i_raddr];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce)
    begin
      o_rdata <= rdata_next;
      if (i_we)
      begin
        mem_array[i_waddr] <= i_wdata;
      end
    end
  end

endmodule

// *** sim/eep_host.sv ***
module eep_host (
  input  wire logic i_clk,
  input  wire logic i_wire,
  output logic      o_cs,
  output logic      o_sclk,
  output logic      o_dat,
  output logic      o_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_cs  = 1'b0;
    o_sclk = 1'b0;
    o_dat = 1'b0;
    o_oe  = 1'b0;
  end

  task automatic sel(input logic v);
    @(negedge i_clk);
    o_cs = v;
    repeat (4) @(negedge i_clk);
  endtask

  task automatic free_pin;
    @(negedge i_clk);
    o_oe = 1'b0;
  endtask

  // ****************************************
  // One serial clock period
  // ****************************************
  // clock parked low
  task automatic bit_cyc(input logic drv, input logic val, output logic seen);
    @(negedge i_clk);
    o_oe  = drv;
    o_dat = val;
    repeat (2) @(negedge i_clk);
    o_sclk = 1'b1;
    repeat (6) @(negedge i_clk);
    o_sclk = 1'b0;
    repeat (4) @(negedge i_clk);
    seen = i_wire;
  endtask

  task automatic send(input logic [26:0] v, input int n);
    logic s;
    for (int i = n - 1; i >= 0; i--)
    begin
      bit_cyc(1'b1, v[i], s);
    end
  endtask

  task automatic recv(output logic [15:0] w);
    logic s;
    for (int i = 15; i >= 0; i--)
    begin
      bit_cyc(1'b0, 1'b0, s);
      w[i] = s;
    end
  endtask
endmodule

// *** sim/shared_data_pin_serial_eeprom_port_tb.sv ***
module shared_data_pin_serial_eeprom_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PROG = 200;

  logic      clk = 1'b0;
  logic      rst;
  logic      ce;
  logic      cs;
  logic      sclk;
  logic      hdat;
  logic      hoe;
  logic      ddat;
  logic      doe;
  wire logic wire_lvl;
  int        n_errors = 0;
  int        cmp_count = 0;

  assign wire_lvl = hoe ? hdat : (doe ? ddat : 1'b1);

  eep_port #(.PROG_CYCLES(PROG)) eep_port_i (
    .i_clk              (clk),
    .i_sys_rst          (rst),
    .i_ce               (ce),
    .i_chip_select_pin  (cs),
    .i_serial_clock_pin (sclk),
    .i_shared_data_pin  (wire_lvl),
    .o_shared_data_pin  (ddat),
    .o_shared_data_oe   (doe)
  );

  eep_host eep_host_i (
    .i_clk  (clk),
    .i_wire (wire_lvl),
    .o_cs   (cs),
    .o_sclk (sclk),
    .o_dat  (hdat),
    .o_oe   (hoe)
  );

  initial
  begin
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Checking and verdict
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Frame helpers
  // ****************************************
  task automatic misc_cmd(input logic [1:0] sub);
    eep_host_i.sel(1'b1);
    eep_host_i.send({16'h0000, 1'b1, eep_pkg::OP_MISC, sub, 6'h00}, 11);
    eep_host_i.sel(1'b0);
  endtask

  // First n bits of the frame, start bit first
  task automatic write_word(input logic [7:0] a, input logic [15:0] d, input int n);
    misc_cmd(eep_pkg::MISC_EWEN);
    eep_host_i.sel(1'b1);
    eep_host_i.send({1'b1, eep_pkg::OP_WRITE, a, d} >> (27 - n), n);
    eep_host_i.free_pin();
  endtask

  task automatic read_word(input logic [7:0] a, output logic [15:0] w);
    eep_host_i.sel(1'b1);
    eep_host_i.send({16'h0000, 1'b1, eep_pkg::OP_READ, a}, 11);
    eep_host_i.recv(w);
    eep_host_i.sel(1'b0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    check(doe, 1'b0);
    check(ddat, 1'b0);
    $display("t_reset done");
  endtask

  task automatic t_write;
    logic [15:0] w;
    logic        s;
    int          k;
    write_word(8'h5A, 16'hA5C3, 27);
    repeat (2) @(negedge clk);
    check(doe, 1'b1);
    check(wire_lvl, eep_pkg::BUSY_LVL);
    for (int i = 0; i < 3; i++)
    begin
      eep_host_i.bit_cyc(1'b1, 1'b1, s);
    end
    eep_host_i.free_pin();
    @(negedge clk);
    check(doe, 1'b1);
    check(ddat, eep_pkg::BUSY_LVL);
    k = 0;
    while (wire_lvl !== eep_pkg::READY_LVL && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    check(wire_lvl, eep_pkg::READY_LVL);
    eep_host_i.bit_cyc(1'b0, 1'b0, s);
    check(doe, 1'b0);
    eep_host_i.send({17'h00000, eep_pkg::OP_READ, 8'h5A}, 10);
    check(doe, 1'b1);
    check(ddat, eep_pkg::DUMMY_BIT);
    eep_host_i.recv(w);
    check(w, 16'hA5C3);
    eep_host_i.sel(1'b0);
    $display("t_write done");
  endtask

  task automatic t_cancel;
    logic [15:0] w;
    write_word(8'h5A, 16'h1234, 26);
    eep_host_i.sel(1'b0);
    check(doe, 1'b0);
    read_word(8'h5A, w);
    check(w, 16'hA5C3);
    write_word(8'h3C, 16'h0F0F, 27);
    eep_host_i.sel(1'b0);
    repeat (PROG + 50) @(negedge clk);
    read_word(8'h3C, w);
    check(w, 16'h0F0F);
    $display("t_cancel done");
  endtask

  task automatic t_misc;
    logic [15:0] w;
    // Write while disabled: no busy phase, word kept
    misc_cmd(eep_pkg::MISC_EWDS);
    eep_host_i.sel(1'b1);
    eep_host_i.send({1'b1, eep_pkg::OP_WRITE, 8'h3C, 16'h1111}, 27);
    eep_host_i.free_pin();
    repeat (4) @(negedge clk);
    check(doe, 1'b0);
    eep_host_i.sel(1'b0);
    read_word(8'h3C, w);
    check(w, 16'h0F0F);
    // Erase commits on the last address bit
    misc_cmd(eep_pkg::MISC_EWEN);
    eep_host_i.sel(1'b1);
    eep_host_i.send({16'h0000, 1'b1, eep_pkg::OP_ERASE, 8'h3C}, 11);
    eep_host_i.free_pin();
    repeat (2) @(negedge clk);
    check(doe, 1'b1);
    check(wire_lvl, eep_pkg::BUSY_LVL);
    // Clock enable low freezes the busy count
    ce = 1'b0;
    repeat (PROG + 50) @(negedge clk);
    check(doe, 1'b1);
    check(wire_lvl, eep_pkg::BUSY_LVL);
    ce = 1'b1;
    eep_host_i.sel(1'b0);
    repeat (PROG + 50) @(negedge clk);
    read_word(8'h3C, w);
    check(w, 16'hFFFF);
    $display("t_misc done");
  endtask

  initial
  begin
    rst = 1'b1;
    ce  = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_write();
    t_cancel();
    t_misc();
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
